// ==== hw/unc_defs.svh ====
`ifndef UNC_DEFS_SVH
`define UNC_DEFS_SVH
// register numbers on the configuration access port
`define UNC_REG_ID        8'h00
`define UNC_REG_NODE_CFG  8'h04
`define UNC_REG_NODE_ID   8'h05
`define UNC_REG_SYS_FREQ  8'h51
`define UNC_REG_LINK_CS   8'h80
// identification fields (values arbitrary)
`define UNC_CHIP_ID       8'hA5
`define UNC_BLK_REV       8'h11
`define UNC_BLK_VER       8'h01
// field positions
`define UNC_CFG_LOCK_BIT  31
`define UNC_CFG_HDR_BIT   0
`define UNC_LCS_ERR_BIT   27
`define UNC_LCS_CRI_BIT   26
`define UNC_LCS_CRH_BIT   25
`define UNC_LCS_HSTOK_BIT 24
`define UNC_LCS_RXRST_BIT 23
// reset values and limits
`define UNC_FREQ_RST      7'h19
`define UNC_FREQ_MIN      7'h05
`define UNC_FREQ_MAX      7'h64
`define UNC_GAP_RST       11'h001
`endif

// ==== hw/unc_pkg.sv ====
package unc_pkg;
  // one configuration access request
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } unc_req_t;
  // answer to a request
  typedef struct packed {
    logic        ack;
    logic        nack;
    logic [31:0] rdata;
  } unc_rsp_t;
endpackage

// ==== hw/unc_config_regs.sv ====
`timescale 1ns/10ps
`include "unc_defs.svh"
// Overview of operation
// - read-only identification word: chip, revision, version
// - lock bit blocks config and link writes
// - config bit 0 selects header format
// - writable 16-bit node identifier, resets zero
// - 7-bit frequency field resets to 25
// - frequency writes outside 5..100 refused, nacked
// - bit 27 flags overflow or illegal token
// - bit 26 shows credit issued to remote
// - bit 25 shows transmit credit held
// - bit 24 clears credit, sends handshake token
// - bit 23 resets the link receiver
// - symbol gap field bits 21:11, resets 1
// - token gap field bits 10:0, resets 1
module unc_config_regs (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // configuration access port
  input  wire logic              req_valid,
  input  wire unc_pkg::unc_req_t req,
  output unc_pkg::unc_rsp_t      rsp,
  // link status from the datapath
  input  wire logic              rx_overflow,
  input  wire logic              rx_illegal_token,
  input  wire logic              credit_issued,
  input  wire logic              credit_held,
  // controls to the link datapath
  output logic                   single_byte_hdr,
  output logic [15:0]            node_id,
  output logic [6:0]             sys_freq_mhz,
  output logic                   credit_clear,
  output logic                   credit_handshake_token,
  output logic                   rx_reset,
  output logic [10:0]            symbol_gap,
  output logic [10:0]            token_gap,
  output logic                   link_error
);

  // register state
  logic              lock_q;
  logic              hdr_q;
  logic [15:0]       nid_q;
  logic [6:0]        freq_q;
  logic [10:0]       sgap_q;
  logic [10:0]       tgap_q;
  logic              err_q;
  logic              cri_q;
  logic              crh_q;
  logic              hstok_q;
  logic              rxrst_q;
  unc_pkg::unc_rsp_t rsp_q;
  unc_pkg::unc_rsp_t rsp_d;
  logic [31:0]       rdata;

  // address decode
  wire wr       = req_valid & req.wr;
  wire hit_id   = req.addr == `UNC_REG_ID;
  wire hit_cfg  = req.addr == `UNC_REG_NODE_CFG;
  wire hit_nid  = req.addr == `UNC_REG_NODE_ID;
  wire hit_freq = req.addr == `UNC_REG_SYS_FREQ;
  wire hit_lcs  = req.addr == `UNC_REG_LINK_CS;
  wire hit_any  = hit_id | hit_cfg | hit_nid | hit_freq | hit_lcs;
  wire [6:0] wfreq = req.wdata[6:0];
  wire freq_ok  = (wfreq >= `UNC_FREQ_MIN) && (wfreq <= `UNC_FREQ_MAX);
  wire wr_cfg   = wr & hit_cfg & ~lock_q;
  wire wr_lcs   = wr & hit_lcs & ~lock_q;
  wire wr_nid   = wr & hit_nid;
  wire wr_freq  = wr & hit_freq & freq_ok;
  wire bad_freq = wr & hit_freq & ~freq_ok;
  wire do_hstok = wr_lcs & req.wdata[`UNC_LCS_HSTOK_BIT];
  wire do_rxrst = wr_lcs & req.wdata[`UNC_LCS_RXRST_BIT];
  wire err_ev   = rx_overflow | rx_illegal_token;

  // read multiplexer; reserved and command bits read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_id)
      rdata = {`UNC_CHIP_ID, 8'h00, `UNC_BLK_REV, `UNC_BLK_VER};
    if (hit_cfg)
      rdata = {lock_q, 30'h0000_0000, hdr_q};
    if (hit_nid)
      rdata = {16'h0000, nid_q};
    if (hit_freq)
      rdata = {25'h000_0000, freq_q};
    if (hit_lcs)
      rdata = {4'h0, err_q, cri_q, crh_q, 3'h0, sgap_q, tgap_q};
  end

  // response: ack for mapped access, nack for bad frequency or unmapped
  always_comb begin
    rsp_d.ack   = req_valid & hit_any & ~bad_freq;
    rsp_d.nack  = req_valid & (~hit_any | bad_freq);
    rsp_d.rdata = (req_valid & ~req.wr) ? rdata : 32'h0000_0000;
  end

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_q <= 1'b0;
      hdr_q  <= 1'b0;
      nid_q  <= 16'h0000;
      freq_q <= `UNC_FREQ_RST;
      sgap_q <= `UNC_GAP_RST;
      tgap_q <= `UNC_GAP_RST;
    end else begin
      if (wr_cfg) begin
        lock_q <= req.wdata[`UNC_CFG_LOCK_BIT];
        hdr_q  <= req.wdata[`UNC_CFG_HDR_BIT];
      end
      if (wr_nid)
        nid_q <= req.wdata[15:0];
      if (wr_freq)
        freq_q <= wfreq;
      if (wr_lcs) begin
        sgap_q <= req.wdata[21:11];
        tgap_q <= req.wdata[10:0];
      end
    end
  end

  // status capture and command pulses
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_q   <= 1'b0;
      cri_q   <= 1'b0;
      crh_q   <= 1'b0;
      hstok_q <= 1'b0;
      rxrst_q <= 1'b0;
      rsp_q   <= '0;
    end else begin
      // error sticks until the receiver is reset; new error wins
      if (err_ev)
        err_q <= 1'b1;
      else if (do_rxrst)
        err_q <= 1'b0;
      cri_q   <= credit_issued;
      crh_q   <= credit_held & ~do_hstok;
      hstok_q <= do_hstok;
      rxrst_q <= do_rxrst;
      rsp_q   <= rsp_d;
    end
  end

  // outputs straight from flip-flops
  assign rsp                    = rsp_q;
  assign single_byte_hdr        = hdr_q;
  assign node_id                = nid_q;
  assign sys_freq_mhz           = freq_q;
  assign credit_clear           = hstok_q;
  assign credit_handshake_token = hstok_q;
  assign rx_reset               = rxrst_q;
  assign symbol_gap             = sgap_q;
  assign token_gap              = tgap_q;
  assign link_error             = err_q;

  // assertions
  // identification word: chip field stands in the top byte
  AST_ID_READ: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && !req.wr && hit_id
      |=> rsp.rdata[31:24] == `UNC_CHIP_ID)
    else $error("identification wrong");
  // identification word: zero byte, revision and version below it
  AST_ID_LOW: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && !req.wr && hit_id
      |=> rsp.rdata[23:0] == {8'h00, `UNC_BLK_REV, `UNC_BLK_VER})
    else $error("identification low bytes wrong");
  // a write to the identification word is answered and changes nothing
  AST_ID_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    wr && hit_id |=> rsp.ack && !rsp.nack && $stable(hdr_q)
      && $stable(nid_q) && $stable(freq_q))
    else $error("identification write misbehaved");
  // once locked, the lock and the locked fields stay put
  AST_LOCK_HOLDS: assert property (@(posedge ref_clk) disable iff (rst)
    lock_q |=> lock_q && $stable(hdr_q) && $stable(sgap_q)
      && $stable(tgap_q))
    else $error("locked config changed");
  // a locked configuration write is acknowledged and ignored
  AST_LOCK_CFG: assert property (@(posedge ref_clk) disable iff (rst)
    wr && hit_cfg && lock_q |=> rsp.ack && !rsp.nack && $stable(hdr_q))
    else $error("locked config write not ignored");
  // a locked link control write issues no command
  AST_LOCK_LCS: assert property (@(posedge ref_clk) disable iff (rst)
    wr && hit_lcs && lock_q
      |=> rsp.ack && !credit_handshake_token && !rx_reset)
    else $error("locked link write took effect");
  // header mode follows bit 0 of an unlocked configuration write
  AST_HDR_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cfg |=> single_byte_hdr == $past(req.wdata[`UNC_CFG_HDR_BIT]))
    else $error("header mode not written");
  // every field leaves reset at its initial value
  AST_RESET_VALUES: assert property (@(posedge ref_clk)
    disable iff (rst) $past(rst) |-> !single_byte_hdr && node_id == 16'h0000
      && sys_freq_mhz == `UNC_FREQ_RST && symbol_gap == `UNC_GAP_RST
      && token_gap == `UNC_GAP_RST && !link_error && !lock_q)
    else $error("reset values wrong");
  // node identifier takes the low half of any write, locked or not
  AST_NID_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    wr && hit_nid |=> node_id == $past(req.wdata[15:0]))
    else $error("node identifier not written");
  // node identifier holds between its writes
  AST_NID_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    !(wr && hit_nid) |=> $stable(node_id))
    else $error("node identifier moved");
  // frequency reads back in the low seven bits
  AST_FREQ_READ: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && !req.wr && hit_freq
      |=> rsp.rdata == {25'h000_0000, sys_freq_mhz})
    else $error("frequency read wrong");
  // the frequency field never leaves the legal range
  AST_FREQ_RANGE: assert property (@(posedge ref_clk) disable iff (rst)
    freq_q >= `UNC_FREQ_MIN && freq_q <= `UNC_FREQ_MAX)
    else $error("frequency out of range");
  // a legal frequency write lands and is acknowledged
  AST_FREQ_TAKE: assert property (@(posedge ref_clk) disable iff (rst)
    wr && hit_freq && freq_ok
      |=> sys_freq_mhz == $past(req.wdata[6:0]) && rsp.ack && !rsp.nack)
    else $error("legal frequency not taken");
  // an illegal frequency write is refused and leaves the field alone
  AST_FREQ_NACK: assert property (@(posedge ref_clk) disable iff (rst)
    bad_freq |=> rsp.nack && !rsp.ack && $stable(freq_q))
    else $error("bad frequency not refused");
  // frequency changes only on an accepted write
  AST_FREQ_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_freq |=> $stable(freq_q))
    else $error("frequency moved");
  // every request gets exactly one answer in the next cycle
  AST_ONE_ANSWER: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid |=> rsp.ack != rsp.nack)
    else $error("answer missing or doubled");
  // no answer without a request
  AST_NO_ANSWER: assert property (@(posedge ref_clk) disable iff (rst)
    !req_valid |=> !rsp.ack && !rsp.nack)
    else $error("answer without request");
  // a fault raises the error flag
  AST_ERR_SET: assert property (@(posedge ref_clk) disable iff (rst)
    err_ev |=> link_error)
    else $error("error flag not set");
  // the error flag sticks until the receiver is reset
  AST_ERR_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    link_error && !do_rxrst |=> link_error)
    else $error("error flag dropped");
  // receiver reset clears the error unless a new one arrives
  AST_ERR_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
    do_rxrst && !err_ev |=> !link_error)
    else $error("error flag not cleared");
  // the error flag rises only with a fault
  AST_ERR_RISE: assert property (@(posedge ref_clk) disable iff (rst)
    !link_error && !err_ev |=> !link_error)
    else $error("error flag without fault");
  // issued credit is shown
  AST_CRI_TRACK: assert property (@(posedge ref_clk) disable iff (rst)
    credit_issued |=> cri_q)
    else $error("issued credit not shown");
  // withdrawn credit is shown as withdrawn
  AST_CRI_DROP: assert property (@(posedge ref_clk) disable iff (rst)
    !credit_issued |=> !cri_q)
    else $error("withdrawn credit shown");
  // held credit is shown unless a handshake clears it
  AST_CRH_TRACK: assert property (@(posedge ref_clk) disable iff (rst)
    credit_held && !do_hstok |=> crh_q)
    else $error("held credit not shown");
  // missing credit is never shown as held
  AST_CRH_DROP: assert property (@(posedge ref_clk) disable iff (rst)
    !credit_held |=> !crh_q)
    else $error("credit shown without credit");
  // status bits read back with reserved bits zero
  AST_LCS_READ: assert property (@(posedge ref_clk)
    disable iff (rst) req_valid && !req.wr && hit_lcs
      |=> rsp.rdata[27:25] == $past({err_q, cri_q, crh_q})
      && rsp.rdata[31:28] == 4'h0 && rsp.rdata[24:22] == 3'h0)
    else $error("link status read wrong");
  // a handshake command sends the token and drops held credit
  AST_HS_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
    do_hstok |=> credit_handshake_token && !crh_q)
    else $error("handshake not issued");
  // no handshake token without a command
  AST_HS_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
    !do_hstok |=> !credit_handshake_token)
    else $error("handshake without command");
  // credit clear and token travel together
  AST_HS_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
    credit_clear == credit_handshake_token)
    else $error("credit clear apart from token");
  // a receiver reset command gives a one-cycle pulse
  AST_RXRST_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
    do_rxrst |=> rx_reset ##1 (!rx_reset || $past(do_rxrst)))
    else $error("receiver reset missing");
  // no receiver reset without a command
  AST_RXRST_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
    !do_rxrst |=> !rx_reset)
    else $error("receiver reset without command");
  // gap fields take their bits from an unlocked link write
  AST_GAP_WRITE: assert property (@(posedge ref_clk)
    disable iff (rst) wr_lcs |=> symbol_gap == $past(req.wdata[21:11])
      && token_gap == $past(req.wdata[10:0]))
    else $error("gap fields not written");
  // gap fields read back in place
  AST_GAP_READ: assert property (@(posedge ref_clk)
    disable iff (rst) req_valid && !req.wr && hit_lcs
      |=> rsp.rdata[21:0] == {symbol_gap, token_gap})
    else $error("gap fields read wrong");
  // configuration read: zeros between lock and header mode
  AST_CFG_READ: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && !req.wr && hit_cfg
      |=> rsp.rdata[30:1] == 30'h0000_0000
      && rsp.rdata[0] == single_byte_hdr)
    else $error("configuration read wrong");
  // node identifier reads with a zero upper half
  AST_NID_READ: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && !req.wr && hit_nid |=> rsp.rdata[31:16] == 16'h0000)
    else $error("node identifier read wrong");
  // unmapped numbers are refused with zero data
  AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && !hit_any
      |=> rsp.nack && !rsp.ack && rsp.rdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  // writes answer with zero data
  AST_WRITE_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && req.wr |=> rsp.rdata == 32'h0000_0000)
    else $error("write answered with data");

endmodule // unc_config_regs

// ==== verif/unc_link_peer.sv ====
`timescale 1ns/10ps
// remote link end: answers a handshake with credit, passes faults on
module unc_link_peer #(
  parameter int DLY = 4
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // handshake token from the block
  input  wire logic       hs,
  // faults requested by the bench
  input  wire logic [1:0] inj,
  // link status to the block
  output logic            ovf,
  output logic            bad,
  output logic            cred
);
  logic [3:0] cnt_q;
  // a handshake drops credit; it comes back DLY cycles later
  always_ff @(posedge ref_clk) begin
    if (rst || hs) cnt_q <= rst ? 4'h0 : 4'(DLY);
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    cred <= !rst && ((cred && !hs) || cnt_q == 4'h1);
  end
  // faults last as long as the bench holds them
  assign ovf = inj[0];
  assign bad = inj[1];
endmodule // unc_link_peer

// ==== verif/tb_usb_node_config_regs.sv ====
`timescale 1ns/10ps
`include "unc_defs.svh"
module tb_usb_node_config_regs;
  logic              ref_clk = 1'h0;
  logic              rst = 1'h1;
  logic              req_valid = 1'h0;
  unc_pkg::unc_req_t req = '0;
  unc_pkg::unc_rsp_t rsp;
  logic [1:0]  inj = 2'h0;
  logic        ovf, bad, cred, hdr, hs, clr, rxr, err, ok;
  logic [15:0] nid;
  logic [6:0]  frq, f;
  logic [10:0] sg, tg, s, t;
  logic [31:0] v, r;
  logic [33:0] x;
  logic [33:0] exp_q[$];
  int mismatches = 0, tests_run = 0, hs_n = 0, rxr_n = 0, seed = 9304;
  int fv[4] = '{4, 5, 100, 101};
  unc_config_regs dut_u (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req(req), .rsp(rsp), .rx_overflow(ovf), .rx_illegal_token(bad),
    .credit_issued(cred), .credit_held(cred), .single_byte_hdr(hdr),
    .node_id(nid), .sys_freq_mhz(frq), .credit_clear(clr),
    .credit_handshake_token(hs), .rx_reset(rxr), .symbol_gap(sg),
    .token_gap(tg), .link_error(err));
  unc_link_peer peer_u (.ref_clk(ref_clk), .rst(rst), .hs(hs), .inj(inj),
    .ovf(ovf), .bad(bad), .cred(cred));
  // clock
  initial forever #25 ref_clk = ~ref_clk;
  task automatic chk(string n, logic [63:0] sn, logic [63:0] e);
    tests_run++;
    if (sn !== e) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", n, e, sn);
    end
  endtask
  // one access; the expected answer is noted for the monitor
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d, logic n,
                     logic [31:0] e);
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req <= '{w, a, d};
    exp_q.push_back({w, n, e});
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge ref_clk) req_valid <= 1'h0;
  endtask
  task automatic fault(logic [1:0] k);
    @(posedge ref_clk) inj <= k;
    req_valid <= 1'h0;
    @(posedge ref_clk) inj <= 2'h0;
    idle(2);
  endtask
  function automatic logic [31:0] lcs(logic e);
    return {4'h0, e, 2'h3, 3'h0, s, t};
  endfunction
  task automatic tally_and_finish;
    chk("pending", exp_q.size(), 33'h0);
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // monitor: answers against the oldest note, command pulses
  always @(posedge ref_clk) begin
    if ((rsp.ack | rsp.nack) === 1'h1) begin
      x = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      chk("answer", {rsp.ack, rsp.nack}, {!x[32], x[32]});
      if (!x[33]) chk("rdata", rsp.rdata, x[31:0]);
    end
    if ((hs | clr) === 1'h1) chk("credit clear", clr, hs);
    hs_n += (hs === 1'h1);
    rxr_n += (rxr === 1'h1);
  end
  // watchdog
  initial begin
    repeat (4000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'h0;
    acc(1'h1, 8'h00, 32'hFFFFFFFF, 1'h0, 32'h0);
    acc(1'h0, 8'h00, 32'h0, 1'h0,
        {`UNC_CHIP_ID, 8'h00, `UNC_BLK_REV, `UNC_BLK_VER});
    acc(1'h0, 8'h51, 32'h0, 1'h0, 32'h19);
    acc(1'h0, 8'h80, 32'h0, 1'h0, 32'h801);
    acc(1'h0, 8'h10, 32'h0, 1'h1, 32'h0);
    f = 7'h19;
    for (int i = 0; i < 12; i++) begin
      v = (i < 4) ? 32'(fv[i]) : 32'($random(seed)) & 32'h7F;
      ok = v >= 32'h5 && v <= 32'h64;
      acc(1'h1, 8'h51, v, !ok, 32'h0);
      if (ok) f = v[6:0];
      acc(1'h0, 8'h51, 32'h0, 1'h0, {25'h0, f});
    end
    acc(1'h1, 8'h04, 32'h7FFFFFFF, 1'h0, 32'h0);
    acc(1'h0, 8'h04, 32'h0, 1'h0, 32'h1);
    r = $random(seed);
    acc(1'h1, 8'h05, r, 1'h0, 32'h0);
    acc(1'h0, 8'h05, 32'h0, 1'h0, {16'h0, r[15:0]});
    s = 11'($random(seed));
    t = 11'($random(seed));
    acc(1'h1, 8'h80, {10'h3FF, s, t}, 1'h0, 32'h0);
    idle(12);
    chk("outputs", {hdr, nid, frq, sg, tg}, {1'h1, r[15:0], f, s, t});
    chk("pulses", {hs_n[3:0], rxr_n[3:0]}, 8'h11);
    acc(1'h0, 8'h80, 32'h0, 1'h0, lcs(1'h0));
    fault(2'h2);
    acc(1'h0, 8'h80, 32'h0, 1'h0, lcs(1'h1));
    acc(1'h1, 8'h80, {10'h002, s, t}, 1'h0, 32'h0);
    idle(2);
    acc(1'h0, 8'h80, 32'h0, 1'h0, lcs(1'h0));
    fault(2'h1);
    acc(1'h0, 8'h80, 32'h0, 1'h0, lcs(1'h1));
    acc(1'h1, 8'h04, 32'h80000000, 1'h0, 32'h0);
    acc(1'h1, 8'h04, 32'h1, 1'h0, 32'h0);
    acc(1'h1, 8'h80, 32'h0, 1'h0, 32'h0);
    acc(1'h0, 8'h04, 32'h0, 1'h0, 32'h80000000);
    acc(1'h0, 8'h80, 32'h0, 1'h0, lcs(1'h1));
    idle(3);
    chk("locked", {hdr, err, sg, tg}, {2'h1, s, t});
    tally_and_finish;
  end
endmodule // tb_usb_node_config_regs
